// file: rtc_pointer_register_access.sv
`timescale 1ns/1ps
module rtc_pointer_register_access
  import rtc_access_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       wren_wr,
  input  wire logic       wren_data,
  input  wire logic       time_ptr_wr,
  input  wire logic [1:0] time_ptr_data,
  input  wire logic       alarm_ptr_wr,
  input  wire logic [1:0] alarm_ptr_data,
  input  wire logic       time_wr_hi,
  input  wire logic       time_wr_lo,
  input  wire logic       time_rd,
  input  wire logic       alarm_wr_hi,
  input  wire logic       alarm_wr_lo,
  input  wire logic       alarm_rd,
  input  wire logic [7:0] wr_data,
  input  wire logic       clk_sel_wr,
  input  wire logic [1:0] clk_sel_data,
  input  wire logic       ref_secondary_crystal_osc,
  input  wire logic       ref_low_power_internal_osc,
  input  wire logic       ref_line,
  output logic [7:0]      time_window_high_byte,
  output logic [7:0]      time_window_low_byte,
  output logic [7:0]      alarm_window_high_byte,
  output logic [7:0]      alarm_window_low_byte,
  output logic [1:0]      time_window_pointer,
  output logic [1:0]      alarm_window_pointer,
  output logic            timer_write_enable,
  output logic [1:0]      reference_clock_select,
  output logic            ref_clk_out
);
  function automatic logic [1:0] dec_ptr(input logic [1:0] p);
    return (p == ptr_min_sec) ? ptr_min_sec : p - 2'h1;
  endfunction

  logic [7:0] tregs [0:6];
  logic [7:0] next_tregs [0:6];
  logic [7:0] aregs [0:5];
  logic [7:0] next_aregs [0:5];
  logic [1:0] next_tptr, next_aptr, next_clk_sel;
  logic       next_wren;
  key_state_e key_state, next_key_state;
  logic [2:0] ref_sync1, ref_sync2;
  logic       next_ref_out;
  logic [7:0] next_thi, next_tlo, next_ahi, next_alo;

  // unlock sequencer: open lasts exactly one cycle after AAh
  always_comb begin
    next_key_state = key_idle;
    if (key_wr && key_data == unlock_key_1) begin
      next_key_state = key_first;
    end else if (key_state == key_first && !key_wr) begin
      next_key_state = key_first;
    end else if (key_state == key_first && key_wr && key_data == unlock_key_2) begin
      next_key_state = key_open;
    end
    case (key_state)
      key_idle, key_first, key_open: ;
      default: next_key_state = key_idle;
    endcase
  end

  always_comb begin
    next_wren = timer_write_enable;
    if (wren_wr) begin
      if (!wren_data) begin
        next_wren = 1'b0;
      end else if (key_state == key_open) begin
        next_wren = 1'b1;
      end
    end
  end

  // index 0 sec,1 min,2 hour,3 wday,4 day,5 month,6 year
  always_comb begin
    for (int i = 0; i < 7; i++) next_tregs[i] = tregs[i];
    for (int i = 0; i < 6; i++) next_aregs[i] = aregs[i];
    next_tptr = time_window_pointer;
    next_aptr = alarm_window_pointer;
    if (timer_write_enable) begin
      // time write routing, empty high byte at year
      case (time_window_pointer)
        ptr_min_sec: begin
          if (time_wr_hi) next_tregs[1] = wr_data;
          if (time_wr_lo) next_tregs[0] = wr_data;
        end
        ptr_wday_hour: begin
          if (time_wr_hi) next_tregs[3] = wr_data;
          if (time_wr_lo) next_tregs[2] = wr_data;
        end
        ptr_month_day: begin
          if (time_wr_hi) next_tregs[5] = wr_data;
          if (time_wr_lo) next_tregs[4] = wr_data;
        end
        default: begin
          if (time_wr_lo) next_tregs[6] = wr_data;
        end
      endcase
    end
    // alarm write routing, nothing at pointer 3
    case (alarm_window_pointer)
      ptr_min_sec: begin
        if (alarm_wr_hi) next_aregs[1] = wr_data;
        if (alarm_wr_lo) next_aregs[0] = wr_data;
      end
      ptr_wday_hour: begin
        if (alarm_wr_hi) next_aregs[3] = wr_data;
        if (alarm_wr_lo) next_aregs[2] = wr_data;
      end
      ptr_month_day: begin
        if (alarm_wr_hi) next_aregs[5] = wr_data;
        if (alarm_wr_lo) next_aregs[4] = wr_data;
      end
      default: ;
    endcase
    // time pointer step on enabled high write, and on read
    if (time_ptr_wr) begin
      next_tptr = time_ptr_data;
    end else if ((time_wr_hi && timer_write_enable) || time_rd) begin
      next_tptr = dec_ptr(time_window_pointer);
    end
    // alarm pointer step on high write, and on read
    if (alarm_ptr_wr) begin
      next_aptr = alarm_ptr_data;
    end else if (alarm_wr_hi || alarm_rd) begin
      next_aptr = dec_ptr(alarm_window_pointer);
    end
  end

  // read view follows the next pointer so the window shows what is selected
  always_comb begin
    next_thi = byte_zero;
    next_tlo = byte_zero;
    next_ahi = byte_zero;
    next_alo = byte_zero;
    case (next_tptr)
      ptr_min_sec: begin next_thi = next_tregs[1]; next_tlo = next_tregs[0]; end
      ptr_wday_hour: begin next_thi = next_tregs[3]; next_tlo = next_tregs[2]; end
      ptr_month_day: begin next_thi = next_tregs[5]; next_tlo = next_tregs[4]; end
      default: next_tlo = next_tregs[6];
    endcase
    case (next_aptr)
      ptr_min_sec: begin next_ahi = next_aregs[1]; next_alo = next_aregs[0]; end
      ptr_wday_hour: begin next_ahi = next_aregs[3]; next_alo = next_aregs[2]; end
      ptr_month_day: begin next_ahi = next_aregs[5]; next_alo = next_aregs[4]; end
      default: ;
    endcase
  end

  // reference source mux on synchronised inputs
  always_comb begin
    next_clk_sel = clk_sel_wr ? clk_sel_data : reference_clock_select;
    case (reference_clock_select)
      clk_sel_secondary_crystal_osc: next_ref_out = ref_sync2[0];
      clk_sel_low_power_internal_osc: next_ref_out = ref_sync2[1];
      clk_sel_line50, clk_sel_line60: next_ref_out = ref_sync2[2];
      default: next_ref_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 7; i++) tregs[i] <= reg_reset;
      for (int i = 0; i < 6; i++) aregs[i] <= reg_reset;
      key_state              <= key_idle;
      timer_write_enable     <= 1'b0;
      time_window_pointer    <= ptr_min_sec;
      alarm_window_pointer   <= ptr_min_sec;
      reference_clock_select <= clk_sel_secondary_crystal_osc;
      ref_sync1              <= 3'h0;
      ref_sync2              <= 3'h0;
      ref_clk_out            <= 1'b0;
      time_window_high_byte  <= byte_zero;
      time_window_low_byte   <= byte_zero;
      alarm_window_high_byte <= byte_zero;
      alarm_window_low_byte  <= byte_zero;
    end else begin
      for (int i = 0; i < 7; i++) tregs[i] <= next_tregs[i];
      for (int i = 0; i < 6; i++) aregs[i] <= next_aregs[i];
      key_state              <= next_key_state;
      timer_write_enable     <= next_wren;
      time_window_pointer    <= next_tptr;
      alarm_window_pointer   <= next_aptr;
      reference_clock_select <= next_clk_sel;
      ref_sync1              <= {ref_line, ref_low_power_internal_osc, ref_secondary_crystal_osc};
      ref_sync2              <= ref_sync1;
      ref_clk_out            <= next_ref_out;
      time_window_high_byte  <= next_thi;
      time_window_low_byte   <= next_tlo;
      alarm_window_high_byte <= next_ahi;
      alarm_window_low_byte  <= next_alo;
    end
  end

  sequence s_key_first;
    key_wr && key_data == unlock_key_1;
  endsequence

  sequence s_key_second;
    key_wr && key_data == unlock_key_2;
  endsequence

  // back-to-back keys; idle gaps get their own fixed-length form
  sequence s_unlock;
    s_key_first ##1 s_key_second;
  endsequence

  sequence s_unlock_gap;
    s_key_first ##1 !key_wr ##1 !key_wr ##1 s_key_second;
  endsequence

  chk_wren_needs_key: assert property (@(posedge clk) disable iff (rst)
    $rose(timer_write_enable) |-> $past(key_state) == key_open)
    else $error("write enable set without unlock");
  chk_unlock_opens: assert property (@(posedge clk) disable iff (rst)
    s_unlock ##1 (wren_wr && wren_data) |=> timer_write_enable)
    else $error("unlock then set failed");
  chk_unlock_gap_opens: assert property (@(posedge clk) disable iff (rst)
    s_unlock_gap ##1 (wren_wr && wren_data) |=> timer_write_enable)
    else $error("unlock with idle gap then set failed");
  chk_tptr_hi_dec: assert property (@(posedge clk) disable iff (rst)
    time_wr_hi && timer_write_enable && !time_ptr_wr && !time_rd |=> time_window_pointer == dec_ptr($past(time_window_pointer)))
    else $error("time pointer did not step on write");
  chk_tptr_lo_hold: assert property (@(posedge clk) disable iff (rst)
    time_wr_lo && !time_wr_hi && !time_rd && !time_ptr_wr |=> $stable(time_window_pointer))
    else $error("time pointer moved on low write");
  chk_tptr_rd_dec: assert property (@(posedge clk) disable iff (rst)
    time_rd && !time_ptr_wr |=> time_window_pointer == dec_ptr($past(time_window_pointer)))
    else $error("time pointer did not step on read");
  chk_aptr_hi_dec: assert property (@(posedge clk) disable iff (rst)
    alarm_wr_hi && !alarm_ptr_wr |=> alarm_window_pointer == dec_ptr($past(alarm_window_pointer)))
    else $error("alarm pointer did not step on write");
  chk_aptr_rd_dec: assert property (@(posedge clk) disable iff (rst)
    alarm_rd && !alarm_ptr_wr |=> alarm_window_pointer == dec_ptr($past(alarm_window_pointer)))
    else $error("alarm pointer did not step on read");
  chk_write_locked: assert property (@(posedge clk) disable iff (rst)
    !timer_write_enable && !time_ptr_wr && !time_rd |=> $stable(time_window_low_byte))
    else $error("time written while locked");
  chk_year_hi_zero: assert property (@(posedge clk) disable iff (rst)
    time_window_pointer == ptr_year |-> time_window_high_byte == byte_zero)
    else $error("empty time byte not zero");
  chk_alarm_empty: assert property (@(posedge clk) disable iff (rst)
    alarm_window_pointer == ptr_year |-> alarm_window_high_byte == byte_zero && alarm_window_low_byte == byte_zero)
    else $error("empty alarm window not zero");
  chk_ref_select: assert property (@(posedge clk) disable iff (rst)
    reference_clock_select == clk_sel_low_power_internal_osc && $stable(reference_clock_select) |=> ref_clk_out == $past(ref_sync2[1]))
    else $error("reference select wrong");
endmodule

// file: rtc_access_pkg.sv
package rtc_access_pkg;
  localparam logic [1:0] ptr_min_sec     = 2'h0;
  localparam logic [1:0] ptr_wday_hour   = 2'h1;
  localparam logic [1:0] ptr_month_day   = 2'h2;
  localparam logic [1:0] ptr_year        = 2'h3;
  localparam logic [7:0] unlock_key_1    = 8'h55;
  localparam logic [7:0] unlock_key_2    = 8'hAA;
  localparam int         wren_bit        = 13;
  localparam logic [7:0] byte_zero       = 8'h00;
  localparam logic [1:0] clk_sel_secondary_crystal_osc    = 2'h0;
  localparam logic [1:0] clk_sel_low_power_internal_osc    = 2'h1;
  localparam logic [1:0] clk_sel_line50  = 2'h2;
  localparam logic [1:0] clk_sel_line60  = 2'h3;
  localparam logic [7:0] reg_reset       = 8'h00;
  typedef enum logic [1:0] {key_idle, key_first, key_open} key_state_e;
endpackage

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import rtc_access_pkg::*;
  logic       clk, rst, key_wr, wren_wr, wren_data, time_ptr_wr, alarm_ptr_wr, clk_sel_wr;
  logic       time_wr_hi, time_wr_lo, time_rd, alarm_wr_hi, alarm_wr_lo, alarm_rd;
  logic       ref_secondary_crystal_osc, ref_low_power_internal_osc, ref_line, timer_write_enable, ref_clk_out, wen;
  logic [7:0] key_data, wr_data, time_window_high_byte, time_window_low_byte;
  logic [7:0] alarm_window_high_byte, alarm_window_low_byte;
  logic [1:0] time_ptr_data, alarm_ptr_data, clk_sel_data, time_window_pointer;
  logic [1:0] alarm_window_pointer, reference_clock_select, tp, ap, cs;
  logic [7:0] tr [8];
  logic [7:0] ar [8];
  logic [10:0] m;
  key_state_e ks;
  int         n_fail, comparisons, quiet;

  rtc_pointer_register_access rtc_pointer_register_access_i (
    .clk, .rst, .key_wr, .key_data, .wren_wr, .wren_data, .time_ptr_wr, .time_ptr_data,
    .alarm_ptr_wr, .alarm_ptr_data, .time_wr_hi, .time_wr_lo, .time_rd, .alarm_wr_hi,
    .alarm_wr_lo, .alarm_rd, .wr_data, .clk_sel_wr, .clk_sel_data, .ref_secondary_crystal_osc, .ref_low_power_internal_osc,
    .ref_line, .time_window_high_byte, .time_window_low_byte, .alarm_window_high_byte,
    .alarm_window_low_byte, .time_window_pointer, .alarm_window_pointer,
    .timer_write_enable, .reference_clock_select, .ref_clk_out);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic model_reset();
    tp = ptr_min_sec; ap = ptr_min_sec; cs = clk_sel_secondary_crystal_osc; wen = 1'b0; ks = key_idle; quiet = 0;
    for (int i = 0; i < 8; i++) begin
      tr[i] = reg_reset;
      ar[i] = reg_reset;
    end
  endtask

  // unmapped slots are never written, so they stay zero in the model
  task automatic step();
    logic [1:0] nt, na;
    logic       open;
    nt = tp; na = ap; open = (ks == key_open);
    if (wen && time_wr_hi && tp != ptr_year) tr[{tp, 1'b1}] = wr_data;
    if (wen && time_wr_lo) tr[{tp, 1'b0}] = wr_data;
    if (((wen && time_wr_hi) || time_rd) && tp != ptr_min_sec) nt = tp - 2'h1;
    if (alarm_wr_hi && ap != ptr_year) ar[{ap, 1'b1}] = wr_data;
    if (alarm_wr_lo && ap != ptr_year) ar[{ap, 1'b0}] = wr_data;
    if ((alarm_wr_hi || alarm_rd) && ap != ptr_min_sec) na = ap - 2'h1;
    if (time_ptr_wr) nt = time_ptr_data;
    if (alarm_ptr_wr) na = alarm_ptr_data;
    if (clk_sel_wr) cs = clk_sel_data;
    if (wren_wr) wen = wren_data & (wen | open);
    if (key_wr) ks = (key_data == unlock_key_1) ? key_first :
                     (ks == key_first && key_data == unlock_key_2) ? key_open : key_idle;
    else if (open) ks = key_idle;
    tp = nt; ap = na;
  endtask

  function automatic logic exp_ref();
    return (cs == clk_sel_secondary_crystal_osc) ? ref_secondary_crystal_osc : (cs == clk_sel_low_power_internal_osc) ? ref_low_power_internal_osc : ref_line;
  endfunction

  task automatic op(input logic [10:0] s);
    {key_wr, wren_wr, time_ptr_wr, alarm_ptr_wr, time_wr_hi, time_wr_lo, time_rd,
     alarm_wr_hi, alarm_wr_lo, alarm_rd, clk_sel_wr} = s;
    if (s[0]) quiet = 0;
    @(posedge clk);
    step();
    @(negedge clk);
    chk({6'h00, time_window_pointer}, {6'h00, tp});
    chk({6'h00, alarm_window_pointer}, {6'h00, ap});
    chk(time_window_high_byte, tr[{tp, 1'b1}]);
    chk(time_window_low_byte, tr[{tp, 1'b0}]);
    chk(alarm_window_high_byte, ar[{ap, 1'b1}]);
    chk(alarm_window_low_byte, ar[{ap, 1'b0}]);
    chk({7'h00, timer_write_enable}, {7'h00, wen});
    chk({6'h00, reference_clock_select}, {6'h00, cs});
    quiet++;
    // synchroniser latency: only compare once source and select have settled
    if (quiet > 4) chk({7'h00, ref_clk_out}, {7'h00, exp_ref()});
  endtask

  task automatic unlock(input int g1, input int g2);
    key_data = unlock_key_1;
    op(11'h400);
    repeat (g1) op(11'h000);
    key_data = unlock_key_2;
    op(11'h400);
    repeat (g2) op(11'h000);
    wren_data = 1'b1;
    op(11'h200);
  endtask

  initial begin
    #100us;
    n_fail++;
    give_verdict();
  end

  initial begin
    rst = 1'b1; key_data = 8'h00; wr_data = 8'h00; wren_data = 1'b0; time_ptr_data = 2'h0;
    alarm_ptr_data = 2'h0; clk_sel_data = 2'h0; {ref_secondary_crystal_osc, ref_low_power_internal_osc, ref_line} = 3'h0;
    {key_wr, wren_wr, time_ptr_wr, alarm_ptr_wr, time_wr_hi, time_wr_lo, time_rd} = 7'h00;
    {alarm_wr_hi, alarm_wr_lo, alarm_rd, clk_sel_wr} = 4'h0;
    n_fail = 0; comparisons = 0;
    model_reset();
    void'($urandom(78));
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    op(11'h000);
    // a foreign key between the two must abort the sequence
    key_data = unlock_key_1;
    op(11'h400);
    key_data = 8'h3C;
    op(11'h400);
    key_data = unlock_key_2;
    op(11'h400);
    wren_data = 1'b1;
    op(11'h200);
    unlock(0, 1);
    unlock(2, 0);
    wr_data = 8'hA5; time_ptr_data = ptr_year;
    op(11'h100);
    op(11'h060);
    wren_data = 1'b0;
    op(11'h200);
    op(11'h040);
    for (int i = 0; i < 1500; i++) begin
      if (i % 8 == 0) begin
        {ref_secondary_crystal_osc, ref_low_power_internal_osc, ref_line} = 3'($urandom);
        quiet = 0;
      end
      wr_data = 8'($urandom); time_ptr_data = 2'($urandom);
      alarm_ptr_data = 2'($urandom); clk_sel_data = 2'($urandom); wren_data = 1'b0;
      // loads only while unlocked, where their lock state is not in doubt
      m = 11'($urandom) & (wen ? 11'h1FF : 11'h07E);
      if ($urandom % 40 == 0) m[9] = 1'b1;
      if (!wen && $urandom % 10 == 0) unlock(0, 0);
      else op(m);
    end
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    model_reset();
    op(11'h000);
    give_verdict();
  end
endmodule
